//--- hw/ddl_top.sv
// input latch front end of a dual ten bit converter
// assumes strobe and clock pins already synchronous to i_clk_sys,
// and a source that keeps its own edge ordering between write and clock
//
// Overview of operation
// - captured word reaches outputs four clocks later
// - ten bit unsigned offset binary words
// - bit nine carries most significant weight
// - mode pin low interleaved, high dual
// - dual mode: independent bus, strobe, clock
// - write edge loads latch, clock moves onward
// - interleaved: first bus only, shared strobes
// - select high first latch, low second
// - unselected latch holds by feedback
// - interleaved words arrive at twice update rate
// - capture on rise, pass on falling edge
// - shared clock halved for converter latches
// - pair reset holds divided clock low
// - pair reset fixes divided clock phase
// - update path runs up to 200 MSPS
`timescale 1ns/100ps
`include "ddl_params.svh"

module ddl_top
    import ddl_pkg::*;
(
    input  wire logic      i_clk_sys,
    input  wire logic      i_reset_n,
    input  wire logic      i_mode_dual,
    input  wire ddl_word_t i_data_first,
    input  wire ddl_word_t i_data_second,
    input  wire logic      i_write_strobe_first_channel,
    input  wire logic      i_write_strobe_second_channel,
    input  wire logic      i_update_clock_first_channel,
    input  wire logic      i_update_clock_second_channel,
    input  wire logic      i_pair_align_reset,
    input  wire logic      i_sample_ready,
    output logic           o_sample_valid,
    output ddl_word_t      o_code_first,
    output ddl_word_t      o_code_second,
    output logic           o_fresh_first,
    output logic           o_fresh_second,
    output logic           o_input_ready,
    output logic           o_divided_converter_clock,
    output logic           o_channel_steer_select
);

    // ********************************************************
    // edge detection on the strobe and clock pins
    // ********************************************************
    ddl_mode_t mode;
    logic      dual;
    logic      prev_wr_first;
    logic      prev_wr_second;
    logic      prev_ck_first;
    logic      prev_ck_second;
    logic      wr_first_rise;
    logic      wr_first_fall;
    logic      wr_second_rise;
    logic      ck_first_rise;
    logic      ck_second_rise;

    // static mode pin picks the interface
    assign mode = i_mode_dual ? DDL_MODE_DUAL : DDL_MODE_INTERLEAVED;
    assign dual = mode == DDL_MODE_DUAL;

    // edges; in interleaved mode the first pins are the shared pins
    assign wr_first_rise  = ddl_rise(i_write_strobe_first_channel, prev_wr_first);
    assign wr_first_fall  = ddl_fall(i_write_strobe_first_channel, prev_wr_first);
    assign wr_second_rise = ddl_rise(i_write_strobe_second_channel, prev_wr_second);
    assign ck_first_rise  = ddl_rise(i_update_clock_first_channel, prev_ck_first);
    assign ck_second_rise = ddl_rise(i_update_clock_second_channel, prev_ck_second);

    // previous pin levels
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            prev_wr_first  <= 1'b0;
            prev_wr_second <= 1'b0;
            prev_ck_first  <= 1'b0;
            prev_ck_second <= 1'b0;
        end
        else
        begin
            prev_wr_first  <= i_write_strobe_first_channel;
            prev_wr_second <= i_write_strobe_second_channel;
            prev_ck_first  <= i_update_clock_first_channel;
            prev_ck_second <= i_update_clock_second_channel;
        end
    end

    // ********************************************************
    // interleave divider and channel steering
    // ********************************************************
    logic next_div;
    logic next_select;
    logic div_rise;

    // halve the shared clock; held low in dual mode or pair reset
    assign next_div = (dual || i_pair_align_reset) ? 1'b0
                    : ck_first_rise ? ~o_divided_converter_clock
                    : o_divided_converter_clock;

    // rising edge of the divided clock loads both converter paths together
    assign div_rise = !dual && !i_pair_align_reset
                    && ck_first_rise && !o_divided_converter_clock;

    // steer toggles per shared write, parked on the first channel in reset
    assign next_select = (dual || i_pair_align_reset) ? `DDL_SELECT_RESET
                       : wr_first_rise ? ~o_channel_steer_select
                       : o_channel_steer_select;

    // divider and steer state
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_divided_converter_clock <= 1'b0;
            o_channel_steer_select    <= `DDL_SELECT_RESET;
        end
        else
        begin
            o_divided_converter_clock <= next_div;
            o_channel_steer_select    <= next_select;
        end
    end

    // ********************************************************
    // channel paths
    // ********************************************************
    ddl_word_t latch_first;
    ddl_word_t latch_second;
    ddl_word_t last_first;
    ddl_word_t last_second;
    ddl_word_t conv_first;
    ddl_word_t conv_second;
    ddl_word_t word_first;
    ddl_word_t word_second;
    logic      load_second;
    logic      hold_pair;
    logic      adv_first;
    logic      adv_second;
    logic      fifo_ready;

    // interleaved: bus goes to the selected latch, the other feeds back
    assign word_first  = (dual || o_channel_steer_select) ? i_data_first
                       : latch_first;
    assign word_second = dual ? i_data_second
                       : o_channel_steer_select ? latch_second
                       : i_data_first;
    assign load_second = dual ? wr_second_rise : wr_first_rise;
    assign hold_pair   = !dual && wr_first_fall;

    // each channel advances on its own clock, or both on the divided clock;
    // one advance per system cycle at most, full fifo stalls the path
    assign adv_first  = (dual ? ck_first_rise : div_rise) && fifo_ready;
    assign adv_second = (dual ? ck_second_rise : div_rise) && fifo_ready;

    ddl_chan u_chan_first
    (
        .i_clk_sys    (i_clk_sys),
        .i_reset_n    (i_reset_n),
        .i_dual       (dual),
        .i_load       (wr_first_rise),
        .i_word       (word_first),
        .i_hold_pair  (hold_pair),
        .i_advance    (adv_first),
        .o_latch      (latch_first),
        .o_stage_last (last_first),
        .o_conv       (conv_first)
    );

    ddl_chan u_chan_second
    (
        .i_clk_sys    (i_clk_sys),
        .i_reset_n    (i_reset_n),
        .i_dual       (dual),
        .i_load       (load_second),
        .i_word       (word_second),
        .i_hold_pair  (hold_pair),
        .i_advance    (adv_second),
        .o_latch      (latch_second),
        .o_stage_last (last_second),
        .o_conv       (conv_second)
    );

    // ********************************************************
    // output stream buffer
    // ********************************************************
    logic [`DDL_FIFO_W-1:0] push_data;
    logic [`DDL_FIFO_W-1:0] head;
    logic                   push_valid;

    // new converter latch contents, bit nine stays the top bit
    assign push_valid = adv_first || adv_second;
    assign push_data  = {adv_second, adv_first,
                         adv_second ? last_second : conv_second,
                         adv_first ? last_first : conv_first};

    ddl_fifo #(
        .WIDTH (`DDL_FIFO_W),
        .DEPTH (`DDL_FIFO_DEPTH)
    ) u_fifo
    (
        .i_clk_sys   (i_clk_sys),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (push_valid),
        .o_in_ready  (fifo_ready),
        .i_in_data   (push_data),
        .o_out_valid (o_sample_valid),
        .i_out_ready (i_sample_ready),
        .o_out_data  (head)
    );

    // head fields, unsigned offset binary codes
    assign o_code_first   = head[`DDL_F_FIRST_LO +: `DDL_WORD_W];
    assign o_code_second  = head[`DDL_F_SECOND_LO +: `DDL_WORD_W];
    assign o_fresh_first  = head[`DDL_F_FRESH_FIRST];
    assign o_fresh_second = head[`DDL_F_FRESH_SEC];
    assign o_input_ready  = fifo_ready;

endmodule

//--- hw/ddl_params.svh
// constants for the dual converter input latch front end
// assumes inclusion by the package and by every design module
`ifndef DDL_PARAMS_SVH
`define DDL_PARAMS_SVH

// ********************************************************
// word and path widths
// ********************************************************
`define DDL_WORD_W        10
`define DDL_STAGES        3
`define DDL_FIFO_DEPTH    8
`define DDL_FIFO_W        22
`define DDL_CNT_W         4

// ********************************************************
// field positions inside a stream word
// ********************************************************
`define DDL_F_FIRST_LO    0
`define DDL_F_SECOND_LO   10
`define DDL_F_FRESH_FIRST 20
`define DDL_F_FRESH_SEC   21

// ********************************************************
// reset values and timing
// ********************************************************
`define DDL_SELECT_RESET  1'b1
`define DDL_WORD_RESET    10'h000
`define DDL_CLK_NS        100
`define DDL_MAX_MSPS      200
`define DDL_LATENCY_CLK   4

`endif

//--- hw/ddl_pkg.sv
// types and helpers shared by the input latch front end
// assumes ddl_params.svh is on the include path
`include "ddl_params.svh"

package ddl_pkg;

    // ********************************************************
    // types
    // ********************************************************
    typedef logic [`DDL_WORD_W-1:0] ddl_word_t;

    typedef enum logic
    {
        DDL_MODE_INTERLEAVED,
        DDL_MODE_DUAL
    } ddl_mode_t;

    // ********************************************************
    // edge detection on a sampled strobe
    // ********************************************************
    function automatic logic ddl_rise(input logic now, input logic prev);
        ddl_rise = now & ~prev;
    endfunction

    function automatic logic ddl_fall(input logic now, input logic prev);
        ddl_fall = ~now & prev;
    endfunction

endpackage

//--- hw/ddl_fifo.sv
// shift register fifo, head at slot 0, all outputs from flops
// assumes one clock and an asynchronous active low reset
`timescale 1ns/100ps
`include "ddl_params.svh"

module ddl_fifo
    import ddl_pkg::*;
#(
    parameter int WIDTH = `DDL_FIFO_W,
    parameter int DEPTH = `DDL_FIFO_DEPTH
)
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);

    logic [WIDTH-1:0]      mem [DEPTH];
    logic [`DDL_CNT_W-1:0] count;
    logic [`DDL_CNT_W-1:0] next_count;
    logic [`DDL_CNT_W-1:0] wr_index;
    logic                  push;
    logic                  pop;

    // handshake decode
    assign push       = i_in_valid & o_in_ready;
    assign pop        = o_out_valid & i_out_ready;
    assign next_count = count + {3'h0, push} - {3'h0, pop};
    assign wr_index   = pop ? count - 4'h1 : count;
    assign o_out_data = mem[0];

    // fill level and flags
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            count       <= 4'h0;
            o_out_valid <= 1'b0;
            o_in_ready  <= 1'b0;
        end
        else
        begin
            count       <= next_count;
            o_out_valid <= next_count != 4'h0;
            o_in_ready  <= next_count != DEPTH[`DDL_CNT_W-1:0];
        end
    end

    // storage: shift on pop, write at the tail
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (push && wr_index == i[`DDL_CNT_W-1:0])
                    mem[i] <= i_in_data;
                else if (pop && i < DEPTH - 1)
                    mem[i] <= mem[i+1];
            end
        end
    end

endmodule

//--- hw/ddl_chan.sv
// one channel: input latch, pair hold register, delay stages, converter latch
// assumes load, fall and advance arrive as one-cycle pulses
`timescale 1ns/100ps
`include "ddl_params.svh"

module ddl_chan
    import ddl_pkg::*;
(
    input  wire logic      i_clk_sys,
    input  wire logic      i_reset_n,
    input  wire logic      i_dual,
    input  wire logic      i_load,
    input  wire ddl_word_t i_word,
    input  wire logic      i_hold_pair,
    input  wire logic      i_advance,
    output ddl_word_t      o_latch,
    output ddl_word_t      o_stage_last,
    output ddl_word_t      o_conv
);

    ddl_word_t pair;
    ddl_word_t stage [`DDL_STAGES];
    ddl_word_t feed;

    // dual mode feeds the stages from the input latch, interleaved from the pair
    assign feed         = i_dual ? o_latch : pair;
    assign o_stage_last = stage[`DDL_STAGES-1];

    // input latch and pair hold
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_latch <= `DDL_WORD_RESET;
            pair    <= `DDL_WORD_RESET;
        end
        else
        begin
            if (i_load)
                o_latch <= i_word;
            if (i_hold_pair)
                pair <= o_latch;
        end
    end

    // delay stages then converter latch, four advances after capture
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            for (int i = 0; i < `DDL_STAGES; i++)
                stage[i] <= `DDL_WORD_RESET;
            o_conv <= `DDL_WORD_RESET;
        end
        else if (i_advance)
        begin
            stage[0] <= feed;
            for (int i = 1; i < `DDL_STAGES; i++)
                stage[i] <= stage[i-1];
            o_conv <= stage[`DDL_STAGES-1];
        end
    end

endmodule

//--- bench/ddl_asserts.sv
// checker for the input latch front end, bound to ddl_top
// assumes pins sampled on i_clk_sys and reset active low
`timescale 1ns/100ps

module ddl_asserts
    import ddl_pkg::*;
(
    input  wire logic      i_clk_sys,
    input  wire logic      i_reset_n,
    input  wire logic      i_mode_dual,
    input  wire logic      i_write_strobe_first_channel,
    input  wire logic      i_update_clock_first_channel,
    input  wire logic      i_pair_align_reset,
    input  wire logic      i_sample_ready,
    input  wire logic      o_sample_valid,
    input  wire ddl_word_t o_code_first,
    input  wire logic      o_divided_converter_clock,
    input  wire logic      o_channel_steer_select
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    // ********************************
    // steps of interleaved operation
    // ********************************
    // interleaved and not held in pairing reset
    wire ilv = !i_mode_dual && !i_pair_align_reset;

    sequence s_pair_release;
        $fell(i_pair_align_reset) && !i_mode_dual;
    endsequence

    sequence s_clk_rise;
        ilv && $rose(i_update_clock_first_channel);
    endsequence

    // ********************************
    // properties
    // ********************************
    chk_div_pair_low: assert property (i_pair_align_reset |=> !o_divided_converter_clock)
        else $error("divided clock high in pairing reset");
    chk_div_toggle_rise: assert property (s_clk_rise |=>
        o_divided_converter_clock != $past(o_divided_converter_clock))
        else $error("divided clock missed a shared clock rise");
    chk_div_hold_idle: assert property ((ilv && !$rose(i_update_clock_first_channel)) |=>
        $stable(o_divided_converter_clock))
        else $error("divided clock moved without a rise");
    chk_sel_toggle_write: assert property ((ilv && $rose(i_write_strobe_first_channel)) |=>
        o_channel_steer_select != $past(o_channel_steer_select))
        else $error("select did not alternate on write");
    chk_sel_pair_force: assert property (i_pair_align_reset |=> o_channel_steer_select)
        else $error("select not first channel in pairing reset");
    chk_dual_static_outs: assert property (i_mode_dual |=>
        o_channel_steer_select && !o_divided_converter_clock)
        else $error("interleave state active in dual mode");
    chk_pair_release_phase: assert property (s_pair_release |->
        o_channel_steer_select && !o_divided_converter_clock)
        else $error("wrong phase at pairing release");
    chk_head_stands: assert property ((o_sample_valid && !i_sample_ready) |=>
        o_sample_valid && $stable(o_code_first))
        else $error("stream head changed while stalled");

    cover property (s_pair_release ##[1:8] s_clk_rise);
endmodule

bind ddl_top ddl_asserts chk (.*);

//--- bench/ddl_source.sv
// data source model: buses, write strobes, update clocks, pairing reset
// assumes the bench calls its tasks; pins change at falling edges
`timescale 1ns/100ps

module ddl_source
    import ddl_pkg::*;
(
    input  wire logic i_clk_sys,
    output logic      o_mode_dual,
    output ddl_word_t o_data_first,
    output ddl_word_t o_data_second,
    output logic      o_write_strobe_first_channel,
    output logic      o_write_strobe_second_channel,
    output logic      o_update_clock_first_channel,
    output logic      o_update_clock_second_channel,
    output logic      o_pair_align_reset
);
    // idle levels at time zero
    initial
    begin
        o_mode_dual = 1'b1;
        {o_data_first, o_data_second} = '0;
        {o_write_strobe_first_channel, o_write_strobe_second_channel} = 2'b00;
        {o_update_clock_first_channel, o_update_clock_second_channel} = 2'b00;
        o_pair_align_reset = 1'b0;
    end

    // mode pin and pairing reset level
    task automatic setup(input logic dual, input logic prst);
        @(negedge i_clk_sys);
        o_mode_dual = dual;
        o_pair_align_reset = prst;
    endtask

    // one period: write and clock rise together, then both fall
    task automatic beat(input logic ch, input ddl_word_t word, input ddl_word_t junk);
        @(negedge i_clk_sys);
        if (ch)
        begin
            o_data_second = word;
            o_write_strobe_second_channel = 1'b1;
            o_update_clock_second_channel = 1'b1;
        end
        else
        begin
            o_data_first = word;
            o_data_second = junk;
            o_write_strobe_first_channel = 1'b1;
            o_update_clock_first_channel = 1'b1;
        end
        @(negedge i_clk_sys);
        // hold time over: bus shows the inverse
        o_data_first = ~o_data_first;
        o_data_second = ~o_data_second;
        {o_write_strobe_first_channel, o_write_strobe_second_channel} = 2'b00;
        {o_update_clock_first_channel, o_update_clock_second_channel} = 2'b00;
    endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench for the input latch front end
// assumes ddl_source drives the pins and the stream side is watched here
`timescale 1ns/100ps
`include "ddl_params.svh"

module tb_top
    import ddl_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        rdy;
    logic        mode, w1, w2, c1, c2, prst, vld, f1, f2, irdy, div, sel;
    ddl_word_t   d1, d2, q1, q2;
    int          bad_count, comparisons, idx;
    logic [31:0] rng;
    ddl_word_t   sent[$];
    logic [21:0] pops[$];

    ddl_source src (.i_clk_sys(clk), .o_mode_dual(mode), .o_data_first(d1),
        .o_data_second(d2), .o_write_strobe_first_channel(w1),
        .o_write_strobe_second_channel(w2), .o_update_clock_first_channel(c1),
        .o_update_clock_second_channel(c2), .o_pair_align_reset(prst));

    ddl_top dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_mode_dual(mode),
        .i_data_first(d1), .i_data_second(d2), .i_write_strobe_first_channel(w1),
        .i_write_strobe_second_channel(w2), .i_update_clock_first_channel(c1),
        .i_update_clock_second_channel(c2), .i_pair_align_reset(prst),
        .i_sample_ready(rdy), .o_sample_valid(vld), .o_code_first(q1),
        .o_code_second(q2), .o_fresh_first(f1), .o_fresh_second(f2),
        .o_input_ready(irdy), .o_divided_converter_clock(div),
        .o_channel_steer_select(sel));

    // ********************************
    // clock, monitor, helpers
    // ********************************
    // 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // record every popped stream entry
    always @(posedge clk)
        if (vld === 1'b1 && rdy === 1'b1)
            pops.push_back({f2, f1, q2, q1});

    function automatic ddl_word_t rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return ddl_word_t'(rng);
    endfunction

    // converter code after the k-th advance
    function automatic ddl_word_t exp_code(int k);
        return (k >= `DDL_LATENCY_CLK) ? sent[k - `DDL_LATENCY_CLK] : `DDL_WORD_RESET;
    endfunction

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (!ok)
        begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    // corner words first, then random
    task automatic send(input logic ch, input int n);
        ddl_word_t w;
        for (int i = 0; i < n; i++)
        begin
            w = (i == 0) ? 10'h3FF : (i == 1) ? 10'h200 : (i == 2) ? 10'h000 : rnd();
            sent.push_back(w);
            src.beat(ch, w, rnd());
        end
    endtask

    // bounded wait until the stream is empty
    task automatic drain();
        @(negedge clk);
        for (int t = 0; t < 40 && vld !== 1'b0; t++)
            @(negedge clk);
    endtask

    task automatic results();
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog: the sequence needs well under 1000 cycles
    initial
    begin
        #200000;
        bad_count++;
        results();
    end

    // ********************************
    // main sequence
    // ********************************
    initial
    begin
        rng = 32'hBBF4E637;
        bad_count = 0;
        comparisons = 0;
        rdy = 1'b1;
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        // dual mode, first channel alone
        send(1'b0, 12);
        drain();
        check(pops.size() == 12, "first channel push count");
        for (int k = 0; k < 12; k++)
            check(pops[k] === {2'b01, `DDL_WORD_RESET, exp_code(k)}, "first code");
        idx = 11;
        pops[0] = {2'b00, `DDL_WORD_RESET, exp_code(idx)};
        sent.delete();
        // second channel alone, first code must stay
        send(1'b1, 8);
        drain();
        check(pops.size() == 20, "second channel push count");
        for (int k = 0; k < 8; k++)
            check(pops[12 + k] === {2'b10, exp_code(k), pops[0][9:0]}, "second code");
        // stalled consumer fills the fifo, advances dropped
        pops.delete();
        rdy = 1'b0;
        send(1'b0, 12);
        check(irdy === 1'b0 && vld === 1'b1, "fifo not full");
        rdy = 1'b1;
        drain();
        check(pops.size() == `DDL_FIFO_DEPTH && vld === 1'b0, "fifo drain");
        // interleaved with pairing reset
        src.setup(1'b0, 1'b1);
        repeat (3) @(negedge clk);
        src.setup(1'b0, 1'b0);
        sent.delete();
        pops.delete();
        send(1'b0, 16);
        drain();
        check(pops.size() == 8, "interleaved push count");
        idx = -1;
        for (int k = 0; k < pops.size(); k++)
            if (idx < 0 && pops[k][19:0] === {sent[1], sent[0]})
                idx = k;
        check(idx >= 0, "first pair not found");
        for (int j = 0; idx >= 0 && idx + j < pops.size(); j++)
            check(pops[idx + j] === {2'b11, sent[2*j+1], sent[2*j]}, "pair");
        results();
    end
endmodule
